// *** usb_addr_irq.sv ***
// Contract
// - Device address clears to zero on power-up and every reset.
// - Endpoints-enable bit 8 is read/write; writing zero disables endpoints.
// - Packets are accepted only while endpoints-enable is set.
// - Enable port: ones set mask bits other than bit 12 (bus-reset-end), zeros do nothing.
// - Disable port: ones clear mask bits other than bit 12 (bus-reset-end), zeros do nothing.
// - Mask view reads current mask, one means enabled.
// - Bus-resume mask bit comes out of reset enabled.
// - Endpoint status bit reads one while that endpoint interrupt pends.
// - Endpoint status rises when any of its cause flags is one.
// - Endpoint status holds until software clears the causing flag.
// - Suspend status sets and suspend entered after idle interval.
// - Frame-start status sets on every start-of-frame token.
// - Bus-reset-end status sets when bus reset sequence finishes.
// - While suspended, remote wake rising edge sets external-resume status.
`timescale 1ns/1ps
`include "usb_addr_irq_defines.svh"

module usb_addr_irq #(
  parameter int IDLE_CYCLES = `UAI_IDLE_CYCLES
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [`UAI_ADDR_W-1:0]      awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [`UAI_ADDR_W-1:0]      araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  input  wire logic [`UAI_NUM_EP-1:0]      epCauseFlags,
  input  wire logic                        busActivity,
  input  wire logic                        frameStartSeen,
  input  wire logic                        busResetEnd,
  input  wire logic                        busResumeSeen,
  input  wire logic                        remoteWakeReq,
  input  wire logic                        tokenValid,
  input  wire logic [`UAI_DEV_ADDR_W-1:0]  tokenAddr,
  output logic                             tokenAccept,
  output logic [`UAI_DEV_ADDR_W-1:0]       deviceAddress,
  output logic                             endpointsEnabled,
  output logic                             suspended,
  output logic                             irq
);

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic [31:0] byteMask(input logic [3:0] strb);
    byteMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : byteMask

  function automatic logic mapped(input logic [`UAI_ADDR_W-1:0] a);
    mapped = (a == `UAI_OFS_FUNC_ADDR) || (a == `UAI_OFS_IRQ_ENABLE) ||
             (a == `UAI_OFS_IRQ_DISABLE) || (a == `UAI_OFS_IRQ_MASK) ||
             (a == `UAI_OFS_IRQ_STATUS);
  endfunction : mapped

  // ********************************************************
  // Write channel capture
  // ********************************************************
  logic [`UAI_ADDR_W-1:0] wrAddr;
  logic                   awHeld;
  logic [31:0]            wrData;
  logic                   wHeld;
  logic                   doWrite;
  logic [31:0]            wrBits;

  assign awready = !awHeld;
  assign wready  = !wHeld;
  assign doWrite = awHeld && wHeld && !bvalid;
  assign wrBits  = wrData;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'h0;
      wrAddr <= '0;
    end else if (awvalid && awready) begin
      awHeld <= 1'h1;
      wrAddr <= awaddr;
    end else if (doWrite) begin
      awHeld <= 1'h0;
    end
  end

  // Disabled lanes are zeroed: at the mask and status ports they set or clear nothing, at the function address they write zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wHeld  <= 1'h0;
      wrData <= '0;
    end else if (wvalid && wready) begin
      wHeld  <= 1'h1;
      wrData <= wdata & byteMask(wstrb);
    end else if (doWrite) begin
      wHeld <= 1'h0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'h0;
      bresp  <= `UAI_RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'h1;
      bresp  <= mapped(wrAddr) ? `UAI_RESP_OKAY : `UAI_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'h0;
    end
  end

  logic wrFuncAddr;
  logic wrEnable;
  logic wrDisable;
  logic wrStatus;

  assign wrFuncAddr = doWrite && (wrAddr == `UAI_OFS_FUNC_ADDR);
  assign wrEnable   = doWrite && (wrAddr == `UAI_OFS_IRQ_ENABLE);
  assign wrDisable  = doWrite && (wrAddr == `UAI_OFS_IRQ_DISABLE);
  assign wrStatus   = doWrite && (wrAddr == `UAI_OFS_IRQ_STATUS);

  // ********************************************************
  // Function address and endpoints enable
  // ********************************************************
  // address reset
  // A finished bus reset also returns the device to the default address
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      deviceAddress <= `UAI_DEV_ADDR_RESET;
    end else if (busResetEnd) begin
      deviceAddress <= `UAI_DEV_ADDR_RESET;
    end else if (wrFuncAddr) begin
      deviceAddress <= wrBits[`UAI_DEV_ADDR_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      endpointsEnabled <= `UAI_EP_ENABLE_RESET;
    end else if (wrFuncAddr) begin
      endpointsEnabled <= wrBits[`UAI_EP_ENABLE_BIT];
    end
  end

  assign tokenAccept = tokenValid && endpointsEnabled && (tokenAddr == deviceAddress);

  // ********************************************************
  // Interrupt mask
  // ********************************************************
  logic [`UAI_IRQ_W-1:0] irqMask;
  logic [`UAI_IRQ_W-1:0] next_irqMask;

  always_comb begin
    next_irqMask = irqMask;
    if (wrEnable) begin
      next_irqMask = irqMask | (wrBits[`UAI_IRQ_W-1:0] & `UAI_MASK_WRITABLE);
    end
    if (wrDisable) begin
      next_irqMask = irqMask & ~(wrBits[`UAI_IRQ_W-1:0] & `UAI_MASK_WRITABLE);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqMask <= `UAI_MASK_RESET;
    end else begin
      irqMask <= next_irqMask;
    end
  end

  // ********************************************************
  // Suspend detection
  // ********************************************************
  usb_addr_irq_pkg::link_state_t linkState;
  logic [$clog2(IDLE_CYCLES+1)-1:0] idleCount;
  logic                             idleDone;

  assign idleDone  = (idleCount == ($clog2(IDLE_CYCLES+1))'(IDLE_CYCLES - 1));
  assign suspended = (linkState == usb_addr_irq_pkg::LINK_SUSPENDED);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idleCount <= '0;
    end else if (busActivity || suspended) begin
      idleCount <= '0;
    end else if (!idleDone) begin
      idleCount <= idleCount + 1'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      linkState <= usb_addr_irq_pkg::LINK_ACTIVE;
    end else begin
      unique case (linkState)
        usb_addr_irq_pkg::LINK_ACTIVE: begin
          if (idleDone && !busActivity) begin
            linkState <= usb_addr_irq_pkg::LINK_SUSPENDED;
          end
        end
        usb_addr_irq_pkg::LINK_SUSPENDED: begin
          if (busActivity) begin
            linkState <= usb_addr_irq_pkg::LINK_ACTIVE;
          end
        end
      endcase
    end
  end

  // ********************************************************
  // Remote wake edge
  // ********************************************************
  logic wakeLevel;
  logic wakeLevelQ;
  logic wakeRise;

  sync_three wakeSync (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn (remoteWakeReq),
    .level   (wakeLevel)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wakeLevelQ <= 1'h0;
    end else begin
      wakeLevelQ <= wakeLevel;
    end
  end

  assign wakeRise = wakeLevel && !wakeLevelQ;

  // ********************************************************
  // Interrupt status
  // ********************************************************
  logic [`UAI_IRQ_W-1:0] irqStatus;
  logic [`UAI_IRQ_W-1:0] eventSet;

  always_comb begin
    eventSet = '0;
    eventSet[`UAI_BIT_SUSPEND]     = idleDone && !busActivity && !suspended;
    eventSet[`UAI_BIT_RESUME]      = busResumeSeen;
    eventSet[`UAI_BIT_EXT_RESUME]  = wakeRise && suspended;
    eventSet[`UAI_BIT_FRAME_START] = frameStartSeen;
    eventSet[`UAI_BIT_RESET_END]   = busResetEnd;
    eventSet[`UAI_BIT_WAKE]        = busResumeSeen || busResetEnd;
  end

  // endpoint bits follow cause, any flag raises, held by flag
  // Endpoint bits carry no state here: the cause flags themselves are sticky
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqStatus <= '0;
    end else begin
      irqStatus[`UAI_NUM_EP-1:0] <= epCauseFlags;
      irqStatus[`UAI_IRQ_W-1:`UAI_NUM_EP] <=
        eventSet[`UAI_IRQ_W-1:`UAI_NUM_EP] |
        (irqStatus[`UAI_IRQ_W-1:`UAI_NUM_EP] &
         ~(wrStatus ? wrBits[`UAI_IRQ_W-1:`UAI_NUM_EP] : '0));
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq <= 1'h0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // ********************************************************
  // Read channel
  // ********************************************************
  assign arready = !rvalid;

  // mask view, write-only ports read zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'h0;
      rdata  <= '0;
      rresp  <= `UAI_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'h1;
      rresp  <= mapped(araddr) ? `UAI_RESP_OKAY : `UAI_RESP_SLVERR;
      unique case (araddr)
        `UAI_OFS_FUNC_ADDR:  rdata <= {23'h0, endpointsEnabled, 1'h0, deviceAddress};
        `UAI_OFS_IRQ_MASK:   rdata <= {18'h0, irqMask};
        `UAI_OFS_IRQ_STATUS: rdata <= {18'h0, irqStatus};
        default:             rdata <= '0;
      endcase
    end else if (rready) begin
      rvalid <= 1'h0;
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  a_addr_reset_zero: assert property (
    @(posedge mclk) disable iff (rst) busResetEnd |=> deviceAddress == `UAI_DEV_ADDR_RESET)
    else $error("address not cleared by bus reset end");

  a_enable_bit_write: assert property (
    @(posedge mclk) disable iff (rst)
    wrFuncAddr |=> endpointsEnabled == $past(wrBits[`UAI_EP_ENABLE_BIT]))
    else $error("endpoints enable did not take written value");

  a_accept_needs_enable: assert property (
    @(posedge mclk) disable iff (rst) tokenAccept |-> endpointsEnabled && tokenValid)
    else $error("packet accepted while endpoints disabled");

  a_enable_sets_mask: assert property (
    @(posedge mclk) disable iff (rst) wrEnable && !wrDisable |=>
      (irqMask & $past(wrBits[`UAI_IRQ_W-1:0] & `UAI_MASK_WRITABLE)) ==
      $past(wrBits[`UAI_IRQ_W-1:0] & `UAI_MASK_WRITABLE))
    else $error("enable port failed to set mask");

  a_disable_clears_mask: assert property (
    @(posedge mclk) disable iff (rst) wrDisable |=>
      (irqMask & $past(wrBits[`UAI_IRQ_W-1:0] & `UAI_MASK_WRITABLE)) == '0)
    else $error("disable port failed to clear mask");

  a_mask_stable_idle: assert property (
    @(posedge mclk) disable iff (rst) !wrEnable && !wrDisable |=> $stable(irqMask))
    else $error("mask changed without a port write");

  a_ep_status_follows: assert property (
    @(posedge mclk) disable iff (rst)
    ##1 irqStatus[`UAI_NUM_EP-1:0] == $past(epCauseFlags))
    else $error("endpoint status does not follow cause flags");

  a_suspend_after_idle: assert property (
    @(posedge mclk) disable iff (rst)
    idleDone && !busActivity && !suspended |=> suspended && irqStatus[`UAI_BIT_SUSPEND])
    else $error("suspend not entered after idle interval");

  a_frame_start_sets: assert property (
    @(posedge mclk) disable iff (rst) frameStartSeen |=> irqStatus[`UAI_BIT_FRAME_START])
    else $error("frame start status not set");

  a_ext_resume_sets: assert property (
    @(posedge mclk) disable iff (rst)
    wakeRise && suspended |=> irqStatus[`UAI_BIT_EXT_RESUME])
    else $error("external resume status not set while suspended");

  a_irq_output_level: assert property (
    @(posedge mclk) disable iff (rst) ##1 irq == |($past(irqStatus) & $past(irqMask)))
    else $error("interrupt output disagrees with status and mask");

endmodule : usb_addr_irq

// *** usb_addr_irq_defines.svh ***
`ifndef USB_ADDR_IRQ_DEFINES_SVH
`define USB_ADDR_IRQ_DEFINES_SVH

// ********************************************************
// Register byte offsets
// ********************************************************
`define UAI_OFS_FUNC_ADDR   12'h008
`define UAI_OFS_IRQ_ENABLE  12'h010
`define UAI_OFS_IRQ_DISABLE 12'h014
`define UAI_OFS_IRQ_MASK    12'h018
`define UAI_OFS_IRQ_STATUS  12'h01C
`define UAI_ADDR_W          12

// ********************************************************
// Field layout
// ********************************************************
`define UAI_DEV_ADDR_W      7
`define UAI_DEV_ADDR_RESET  7'h00
`define UAI_EP_ENABLE_BIT   8
`define UAI_EP_ENABLE_RESET 1'h0
`define UAI_NUM_EP          8
`define UAI_IRQ_W           14
`define UAI_BIT_SUSPEND     8
`define UAI_BIT_RESUME      9
`define UAI_BIT_EXT_RESUME  10
`define UAI_BIT_FRAME_START 11
`define UAI_BIT_RESET_END   12
`define UAI_BIT_WAKE        13
`define UAI_MASK_RESET      14'h1200
`define UAI_MASK_WRITABLE   14'h2FFF
`define UAI_STATUS_W1C      14'h3F00

// ********************************************************
// Bus answers and timing
// ********************************************************
`define UAI_RESP_OKAY       2'h0
`define UAI_RESP_SLVERR     2'h2
`define UAI_MCLK_HZ         10000000
`define UAI_IDLE_MS         3
`define UAI_IDLE_CYCLES     ((`UAI_IDLE_MS * `UAI_MCLK_HZ) / 1000)

`endif

// *** usb_addr_irq_pkg.sv ***
package usb_addr_irq_pkg;

  typedef enum logic {
    LINK_ACTIVE,
    LINK_SUSPENDED
  } link_state_t;

endpackage : usb_addr_irq_pkg

// *** sync_three.sv ***
`timescale 1ns/1ps

module sync_three (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      level
);

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1 <= 1'h0;
      s2 <= 1'h0;
      s3 <= 1'h0;
    end else begin
      s1 <= asyncIn;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Level moves only once the two late stages agree
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      level <= 1'h0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end

endmodule : sync_three

// *** usb_host_model.sv ***
`timescale 1ns/1ps

module usb_host_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  output logic            busActivity,
  output logic            frameStartSeen,
  output logic            busResetEnd,
  output logic            busResumeSeen,
  output logic            tokenValid,
  output logic [6:0]      tokenAddr,
  input  wire logic       tokenAccept
);
  logic idle = 1'b0;

  initial begin
    frameStartSeen = 1'b0;
    busResetEnd    = 1'b0;
    busResumeSeen  = 1'b0;
    tokenValid     = 1'b0;
    tokenAddr      = 7'h00;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busActivity <= 1'b0;
    end else begin
      busActivity <= !idle;
    end
  end

  task automatic setIdle(input logic v);
    @(posedge mclk);
    idle <= v;
  endtask : setIdle

  task automatic sendEvent(input int kind);
    @(posedge mclk);
    frameStartSeen <= (kind == 0);
    busResetEnd    <= (kind == 1);
    busResumeSeen  <= (kind == 2);
    @(posedge mclk);
    frameStartSeen <= 1'b0;
    busResetEnd    <= 1'b0;
    busResumeSeen  <= 1'b0;
  endtask : sendEvent

  // Released address lines show the inverse so a stale value cannot pass
  task automatic sendToken(input logic [6:0] a, output logic acc);
    @(posedge mclk);
    tokenValid <= 1'b1;
    tokenAddr  <= a;
    @(posedge mclk);
    acc = tokenAccept;
    tokenValid <= 1'b0;
    tokenAddr  <= ~a;
  endtask : sendToken
endmodule : usb_host_model

// *** usb_device_address_and_irq_tb.sv ***
`timescale 1ns/1ps
`include "usb_addr_irq_defines.svh"

module usb_device_address_and_irq_tb;
  localparam int          IDLE = 20;
  localparam logic [11:0] FA = `UAI_OFS_FUNC_ADDR;
  localparam logic [11:0] IE = `UAI_OFS_IRQ_ENABLE;
  localparam logic [11:0] ID = `UAI_OFS_IRQ_DISABLE;
  localparam logic [11:0] IM = `UAI_OFS_IRQ_MASK;
  localparam logic [11:0] IS = `UAI_OFS_IRQ_STATUS;
  localparam logic [1:0]  OK = `UAI_RESP_OKAY;
  localparam logic [1:0]  SE = `UAI_RESP_SLVERR;
  localparam logic [11:0] MP [4] = '{IE, ID, ID, IE};
  localparam logic [31:0] MD [4] = '{32'hFFFF_FFFF, 32'h0000_00F0, 32'hFFFF_FFFF, 32'h0000_0200};
  localparam logic [31:0] MX [4] = '{32'h0000_3FFF, 32'h0000_3F0F, 32'h0000_1000, 32'h0000_1200};

  logic        mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, busActivity, frameStartSeen;
  logic        busResetEnd, busResumeSeen, remoteWakeReq, tokenValid, tokenAccept;
  logic        endpointsEnabled, suspended, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  epCauseFlags;
  logic [6:0]  tokenAddr, deviceAddress;
  int          errorCnt = 0;
  int          testsRun = 0;

  usb_addr_irq #(.IDLE_CYCLES(IDLE)) dut (
    .mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .epCauseFlags(epCauseFlags), .busActivity(busActivity),
    .frameStartSeen(frameStartSeen), .busResetEnd(busResetEnd), .busResumeSeen(busResumeSeen),
    .remoteWakeReq(remoteWakeReq), .tokenValid(tokenValid), .tokenAddr(tokenAddr),
    .tokenAccept(tokenAccept), .deviceAddress(deviceAddress), .endpointsEnabled(endpointsEnabled),
    .suspended(suspended), .irq(irq)
  );

  usb_host_model host (
    .mclk(mclk), .rst(rst), .busActivity(busActivity), .frameStartSeen(frameStartSeen),
    .busResetEnd(busResetEnd), .busResumeSeen(busResumeSeen), .tokenValid(tokenValid),
    .tokenAddr(tokenAddr), .tokenAccept(tokenAccept)
  );

  // ********************************************************
  // Clock, watchdog and verdict
  // ********************************************************
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errorCnt++;
    finishTest();
  end

  task automatic finishTest;
    $display("Checks run %0d, mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finishTest

  // ********************************************************
  // Bus tasks
  // ********************************************************
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic doReset;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
  endtask : doReset

  // Write address and data are released each on its own handshake
  task automatic writeReg(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic awDone, wDone, bDone;
    awDone = 1'b0;
    wDone  = 1'b0;
    bDone  = 1'b0;
    @(posedge mclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!bDone) begin
      @(posedge mclk);
      if (!awDone && awready) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        bDone = 1'b1;
        bready <= 1'b0;
        cmp("bresp", er, bresp);
      end
    end
  endtask : writeReg

  task automatic expectReg(input string nm, input logic [11:0] a, input logic [31:0] exp,
                           input logic [1:0] er);
    logic arDone, rDone;
    arDone = 1'b0;
    rDone  = 1'b0;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!rDone) begin
      @(posedge mclk);
      if (!arDone && arready) begin
        arDone = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        rDone = 1'b1;
        rready <= 1'b0;
        cmp(nm, exp, rdata);
        cmp("rresp", er, rresp);
      end
    end
  endtask : expectReg

  // ********************************************************
  // Tests
  // ********************************************************
  initial begin
    logic acc;
    rst = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    remoteWakeReq = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    epCauseFlags = 8'h00;
    doReset();
    expectReg("function_address", FA, 32'h0000_0000, OK);
    expectReg("irq_mask_view", IM, 32'h0000_1200, OK);
    expectReg("irq_status", IS, 32'h0000_0000, OK);
    expectReg("irq_enable_port", IE, 32'h0000_0000, OK);
    expectReg("irq_disable_port", ID, 32'h0000_0000, OK);
    expectReg("unmapped", 12'h0FC, 32'h0000_0000, SE);
    writeReg(12'h0FC, 32'hFFFF_FFFF, SE);
    host.sendEvent(1);
    expectReg("irq_status", IS, 32'h0000_3000, OK);
    cmp("irq", 32'h1, irq);
    writeReg(IS, 32'h0000_3F00, OK);
    expectReg("irq_status", IS, 32'h0000_0000, OK);
    cmp("irq", 32'h0, irq);
    writeReg(FA, 32'h0000_0100, OK);
    cmp("endpointsEnabled", 32'h1, endpointsEnabled);
    host.sendToken(7'h00, acc);
    cmp("tokenAccept", 32'h1, acc);
    writeReg(FA, 32'hFFFF_FFA5, OK);
    expectReg("function_address", FA, 32'h0000_0125, OK);
    cmp("deviceAddress", 32'h25, deviceAddress);
    host.sendToken(7'h25, acc);
    cmp("tokenAccept", 32'h1, acc);
    host.sendToken(7'h00, acc);
    cmp("tokenAccept", 32'h0, acc);
    writeReg(FA, 32'h0000_0025, OK);
    cmp("endpointsEnabled", 32'h0, endpointsEnabled);
    host.sendToken(7'h25, acc);
    cmp("tokenAccept", 32'h0, acc);
    host.sendEvent(1);
    expectReg("function_address", FA, 32'h0000_0000, OK);
    writeReg(IS, 32'h0000_3F00, OK);
    for (int i = 0; i < 4; i++) begin
      writeReg(MP[i], MD[i], OK);
      expectReg("irq_mask_view", IM, MX[i], OK);
    end
    writeReg(IE, 32'h0000_0001, OK);
    for (int i = 0; i < 8; i++) begin
      epCauseFlags <= 8'h01 << i;
      tick(2);
      writeReg(IS, 32'h0000_00FF, OK);
      expectReg("irq_status", IS, 32'h0000_0001 << i, OK);
      cmp("irq", (i == 0), irq);
      epCauseFlags <= 8'h00;
      tick(2);
      expectReg("irq_status", IS, 32'h0000_0000, OK);
    end
    host.sendEvent(0);
    expectReg("irq_status", IS, 32'h0000_0800, OK);
    cmp("irq", 32'h0, irq);
    host.sendEvent(2);
    expectReg("irq_status", IS, 32'h0000_2A00, OK);
    cmp("irq", 32'h1, irq);
    writeReg(IS, 32'h0000_3F00, OK);
    remoteWakeReq <= 1'b1;
    tick(8);
    expectReg("irq_status", IS, 32'h0000_0000, OK);
    remoteWakeReq <= 1'b0;
    tick(8);
    // Suspend must be unmasked for the interrupt check below
    writeReg(IE, 32'h0000_0100, OK);
    host.setIdle(1'b1);
    tick(IDLE + 6);
    cmp("suspended", 32'h1, suspended);
    expectReg("irq_status", IS, 32'h0000_0100, OK);
    cmp("irq", 32'h1, irq);
    remoteWakeReq <= 1'b1;
    tick(8);
    expectReg("irq_status", IS, 32'h0000_0500, OK);
    host.setIdle(1'b0);
    tick(4);
    cmp("suspended", 32'h0, suspended);
    remoteWakeReq <= 1'b0;
    writeReg(FA, 32'h0000_017F, OK);
    expectReg("function_address", FA, 32'h0000_017F, OK);
    // Only lane 0 enabled: the enable bit in lane 1 is written as zero
    wstrb <= 4'h1;
    writeReg(FA, 32'h0000_0155, OK);
    expectReg("function_address", FA, 32'h0000_0055, OK);
    wstrb <= 4'hF;
    doReset();
    expectReg("function_address", FA, 32'h0000_0000, OK);
    expectReg("irq_mask_view", IM, 32'h0000_1200, OK);
    expectReg("irq_status", IS, 32'h0000_0000, OK);
    cmp("deviceAddress", 32'h0, deviceAddress);
    finishTest();
  end
endmodule : usb_device_address_and_irq_tb
